// ---- dsp_accum_saturate_round_shift.sv ----
// Functional notes
// - every adder op updates the target guard flag from bits 31..39 (guard bits 32..39 against bit 31)
// - guard flag set with its guard trap enable raises arithmetic trap
// - limit-hit flags are sticky; only a software write or reset clears them
// - limit-hit means bit 31 or bit 39 overflow per mode, bit 39 unsaturated
// - catastrophic trap enable plus no saturation traps on bit 39 overflow
// - status shows OR of guard flags and OR of limit-hit flags
// - 40-bit saturation loads max positive or negative 9.31, sets limit-hit
// - 32-bit saturation loads max positive or negative 1.31; guard flags never set
// - catastrophic mode sets limit-hit on bit 39, wraps, may trap
// - mac-class ops except multiply and squared-difference forms may write back
// - write-back goes to pointer directly, or to memory then pointer plus 2
// - round style selects conventional or convergent; no round truncates
// - conventional rounding increments high word when low word is 0x8000 or more
// - convergent rounding at exactly 0x8000 increments only when bit 16 is one
// - stores write truncated or rounded target; write-back always rounded
// - store limit forces 0x7FFF above 0x007FFF, accumulator untouched
// - store limit forces 0x8000 below 0xFF8000, sign from bit 39
// - store limit clear passes the 1.15 value unchanged
// - signed shift amount: positive right, negative left, zero unchanged
// - shifts up to 16 bits, arithmetic or logical, from accumulator or bus
// - 40-bit and 16-bit results; bus data at 16..31 right, 0..15 left
// - saturation uses adder result, overflow, limit enables and width select
`timescale 1ns/1ns
module dsp_accum_saturate_round_shift #(
    parameter int unsigned MAX_SHIFT = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire dsp_pkg::dsp_op_s op,
    input wire logic [15:0] writeback_pointer,
    output dsp_pkg::xbus_wr_s xbus_wr,
    output dsp_pkg::ptr_wr_s ptr_wr,
    output logic [39:0] shift_result,
    output logic [15:0] shift_word,
    output logic arith_trap
);

    if (MAX_SHIFT < 1 || MAX_SHIFT > 16)
    begin : g_bad_shift
        $error("MAX_SHIFT must lie in 1..16");
    end
    logic [39:0] acca_q;
    logic [39:0] accb_q;
    logic [7:0] core_ctrl_q;
    logic [2:0] trap_ctrl_q;
    logic guard_a_q;
    logic guard_b_q;
    logic limit_a_q;
    logic limit_b_q;
    logic trap_q;
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    logic [15:0] status_word;
    logic ap_go;
    logic wr_status;
    // control fields
    logic limit_en_a;
    logic limit_en_b;
    logic store_limit;
    logic width40;
    logic round_conv;
    assign limit_en_a = core_ctrl_q[dsp_pkg::POS_LIMIT_EN_A];
    assign limit_en_b = core_ctrl_q[dsp_pkg::POS_LIMIT_EN_B];
    assign store_limit = core_ctrl_q[dsp_pkg::POS_STORE_LIMIT];
    assign width40 = core_ctrl_q[dsp_pkg::POS_LIMIT_WIDTH];
    assign round_conv = core_ctrl_q[dsp_pkg::POS_ROUND_STYLE];
    // bus slave: zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_go = hsel && htrans[1] && hready;
    // address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end
        else
        begin
            dp_wr_q <= ap_go && hwrite;
            dp_addr_q <= ap_go ? haddr[7:0] : dp_addr_q;
        end
    end
    // control register writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            core_ctrl_q <= dsp_pkg::CORE_CTRL_RST;
            trap_ctrl_q <= dsp_pkg::TRAP_CTRL_RST;
        end
        else if (dp_wr_q)
        begin
            if (dp_addr_q == dsp_pkg::OFS_CORE_CTRL)
                core_ctrl_q <= hwdata[7:0];
            if (dp_addr_q == dsp_pkg::OFS_TRAP_CTRL)
                trap_ctrl_q <= hwdata[2:0];
        end
    end
    assign wr_status = dp_wr_q && (dp_addr_q == dsp_pkg::OFS_STATUS);
    always_comb
    begin
        status_word = 16'h0000;
        status_word[dsp_pkg::POS_GUARD_A] = guard_a_q;
        status_word[dsp_pkg::POS_GUARD_B] = guard_b_q;
        status_word[dsp_pkg::POS_LIMIT_A] = limit_a_q;
        status_word[dsp_pkg::POS_LIMIT_B] = limit_b_q;
        status_word[dsp_pkg::POS_EITHER_GUARD] = guard_a_q | guard_b_q;
        status_word[dsp_pkg::POS_EITHER_LIMIT] = limit_a_q | limit_b_q;
    end

    // read mux over data-phase address, flops only
    always_comb
    begin
        unique case (dp_addr_q)
            dsp_pkg::OFS_CORE_CTRL: hrdata = {24'h000000, core_ctrl_q};
            dsp_pkg::OFS_TRAP_CTRL: hrdata = {29'h00000000, trap_ctrl_q};
            dsp_pkg::OFS_STATUS: hrdata = {16'h0000, status_word};
            dsp_pkg::OFS_ACCA_LO: hrdata = acca_q[31:0];
            dsp_pkg::OFS_ACCA_HI: hrdata = {24'h000000, acca_q[39:32]};
            dsp_pkg::OFS_ACCB_LO: hrdata = accb_q[31:0];
            dsp_pkg::OFS_ACCB_HI: hrdata = {24'h000000, accb_q[39:32]};
            default: hrdata = 32'h00000000;
        endcase
    end
    // adder/subtracter
    logic [39:0] acc_tgt;
    logic [39:0] lhs;
    logic [39:0] rhs;
    logic [39:0] sum;
    logic ovf39;
    logic guard_ovf;
    logic sat_en;
    logic limit_evt;
    logic guard_new;
    logic true_neg;
    logic [39:0] acc_next;
    logic trap_evt;
    assign acc_tgt = op.add_target_b ? accb_q : acca_q;
    assign lhs = op.add_zero ? 40'h00_0000_0000 : acc_tgt;
    assign rhs = op.add_sub ? ~op.addend : op.addend;
    assign sum = lhs + rhs + {39'h0, op.add_sub};
    assign ovf39 = (lhs[39] == rhs[39]) && (sum[39] != lhs[39]);
    assign guard_ovf = !(&sum[39:31]) && (|sum[39:31]);
    assign true_neg = ovf39 ? lhs[39] : sum[39];
    assign sat_en = op.add_target_b ? limit_en_b : limit_en_a;
    assign limit_evt = sat_en ? (width40 ? ovf39 : (ovf39 | guard_ovf)) : ovf39;
    // no guard flags in 32-bit saturation
    assign guard_new = guard_ovf && !(sat_en && !width40);
    // saturation value select
    always_comb
    begin
        acc_next = sum;
        if (sat_en && limit_evt && width40)
            acc_next = true_neg ? dsp_pkg::SAT40_NEG : dsp_pkg::SAT40_POS;
        else if (sat_en && limit_evt)
            acc_next = true_neg ? dsp_pkg::SAT32_NEG : dsp_pkg::SAT32_POS;
    end
    assign trap_evt = op.add_en &&
        ((guard_new && (op.add_target_b ? trap_ctrl_q[dsp_pkg::POS_GUARD_TRAP_B]
                                        : trap_ctrl_q[dsp_pkg::POS_GUARD_TRAP_A])) ||
         (!sat_en && ovf39 && trap_ctrl_q[dsp_pkg::POS_CAT_TRAP]));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acca_q <= 40'h00_0000_0000;
            accb_q <= 40'h00_0000_0000;
        end
        else if (op.add_en)
        begin
            if (op.add_target_b)
                accb_q <= acc_next;
            else
                acca_q <= acc_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            guard_a_q <= 1'b0;
            guard_b_q <= 1'b0;
        end
        else if (op.add_en)
        begin
            if (op.add_target_b)
                guard_b_q <= guard_new;
            else
                guard_a_q <= guard_new;
        end
    end

    // sticky limit flags, set beats clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            limit_a_q <= 1'b0;
            limit_b_q <= 1'b0;
        end
        else
        begin
            limit_a_q <= (op.add_en && !op.add_target_b && limit_evt) ||
                (limit_a_q && !(wr_status && hwdata[dsp_pkg::POS_LIMIT_A]));
            limit_b_q <= (op.add_en && op.add_target_b && limit_evt) ||
                (limit_b_q && !(wr_status && hwdata[dsp_pkg::POS_LIMIT_B]));
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            trap_q <= 1'b0;
        else
            trap_q <= trap_evt;
    end
    assign arith_trap = trap_q;

    // store and write-back source, rounding and limiting
    logic wb_go;
    logic st_src_b;
    logic st_round;
    logic [39:0] st_src;
    logic st_inc;
    logic [24:0] st_ext;
    logic [15:0] st_word;
    assign wb_go = op.wb_en && !op.store_en &&
        (op.op_class == dsp_pkg::class_mac || op.op_class == dsp_pkg::class_other);
    assign st_src_b = op.store_en ? op.store_src_b : !op.add_target_b;
    assign st_round = op.store_en ? op.store_round : 1'b1;
    assign st_src = st_src_b ? accb_q : acca_q;
    // style select, truncate when no rounding
    assign st_inc = st_round && st_src[15] &&
        (round_conv || (st_src[14:0] != 15'h0000) || st_src[16]);
    assign st_ext = {st_src[39], st_src[39:16]} + {24'h000000, st_inc};

    // write saturation, source accumulator untouched
    always_comb
    begin
        st_word = st_ext[15:0];
        if (store_limit && !st_src[39] && $signed(st_ext) > dsp_pkg::STORE_UPPER)
            st_word = dsp_pkg::STORE_MAX;
        // negative limit, sign from bit 39
        else if (store_limit && st_src[39] && $signed(st_ext) < dsp_pkg::STORE_LOWER)
            st_word = dsp_pkg::STORE_MIN;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            xbus_wr <= '0;
            ptr_wr <= '0;
        end
        else
        begin
            xbus_wr.en <= op.store_en || (wb_go && op.wb_indirect);
            xbus_wr.addr <= op.store_en ? op.store_addr : writeback_pointer;
            xbus_wr.data <= st_word;
            ptr_wr.en <= wb_go;
            ptr_wr.value <= op.wb_indirect ? writeback_pointer + dsp_pkg::WB_PTR_STEP
                                           : st_word;
        end
    end

    // barrel shifter
    logic [39:0] sh_in;
    logic [5:0] sh_mag;
    logic [5:0] sh_lim;
    logic sh_left;
    logic [39:0] sh_out;
    assign sh_left = op.shift_amt[5];
    assign sh_mag = sh_left ? 6'(-op.shift_amt) : 6'(op.shift_amt);
    assign sh_lim = (sh_mag > 6'(MAX_SHIFT)) ? 6'(MAX_SHIFT) : sh_mag;

    always_comb
    begin
        unique case (op.shift_src)
            dsp_pkg::src_acc_a: sh_in = acca_q;
            dsp_pkg::src_acc_b: sh_in = accb_q;
            default:
                if (sh_left)
                    sh_in = {24'h000000, op.xbus_data};
                else if (op.shift_logical)
                    sh_in = {8'h00, op.xbus_data, 16'h0000};
                else
                    sh_in = {{8{op.xbus_data[15]}}, op.xbus_data, 16'h0000};
        endcase
    end

    always_comb
    begin
        if (sh_left)
            sh_out = sh_in << sh_lim;
        else if (op.shift_logical)
            sh_out = sh_in >> sh_lim;
        else
            sh_out = 40'($signed(sh_in) >>> sh_lim);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            shift_result <= 40'h00_0000_0000;
            shift_word <= 16'h0000;
        end
        else if (op.shift_en)
        begin
            shift_result <= sh_out;
            shift_word <= (op.shift_src == dsp_pkg::src_xbus && sh_left) ? sh_out[15:0]
                                                                       : sh_out[31:16];
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_guard_clear: assert property (
        op.add_en && !op.add_target_b && !guard_ovf |=> !guard_a_q)
        else $error("guard flag a not cleared");
    a_guard_trap: assert property (
        op.add_en && guard_new && !op.add_target_b &&
        trap_ctrl_q[dsp_pkg::POS_GUARD_TRAP_A] |=> arith_trap && guard_a_q)
        else $error("guard trap missing");
    a_limit_sticky: assert property (
        limit_a_q && !(wr_status && hwdata[dsp_pkg::POS_LIMIT_A]) |=> limit_a_q)
        else $error("limit flag a dropped");
    a_cat_limit: assert property (
        op.add_en && !op.add_target_b && !sat_en && ovf39 |=> limit_a_q &&
        acca_q == $past(sum))
        else $error("catastrophic overflow mishandled");
    a_either_bits: assert property (
        hrdata[dsp_pkg::POS_EITHER_LIMIT] == (limit_a_q | limit_b_q) ||
        dp_addr_q != dsp_pkg::OFS_STATUS)
        else $error("either limit bit wrong");
    a_sat40_load: assert property (
        op.add_en && !op.add_target_b && limit_en_a && width40 && ovf39 && !lhs[39]
        |=> acca_q == dsp_pkg::SAT40_POS && limit_a_q)
        else $error("40-bit saturation wrong");
    a_sat32_guard: assert property (
        op.add_en && !op.add_target_b && limit_en_a && !width40 |=> !guard_a_q)
        else $error("guard set in 32-bit mode");
    a_trap_pulse: assert property (
        arith_trap |-> $past(trap_evt))
        else $error("trap without cause");
    a_wb_step: assert property (
        ptr_wr.en && xbus_wr.en |-> ptr_wr.value == xbus_wr.addr + dsp_pkg::WB_PTR_STEP)
        else $error("pointer step wrong");
    a_store_pos: assert property (
        op.store_en && store_limit && !st_src[39] && $signed(st_ext) > dsp_pkg::STORE_UPPER
        |=> xbus_wr.en && xbus_wr.data == dsp_pkg::STORE_MAX)
        else $error("positive store limit missed");
    a_shift_zero: assert property (
        op.shift_en && op.shift_amt == 6'sd0 && op.shift_src == dsp_pkg::src_acc_a
        |=> shift_result == $past(acca_q))
        else $error("zero shift changed operand");

endmodule // dsp_accum_saturate_round_shift

// ---- dsp_accum_saturate_round_shift_tb_top.sv ----
`timescale 1ns/1ns
module dsp_accum_saturate_round_shift_tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, arith_trap, cv, sd, rr, lg, ok, ind;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [39:0] shift_result, v, e;
    logic [15:0] shift_word, ptr, wcnt, w, p;
    dsp_pkg::dsp_op_s op, o;
    dsp_pkg::xbus_wr_s xbus_wr;
    dsp_pkg::ptr_wr_s ptr_wr;
    dsp_pkg::op_class_e c;
    int fails, tests_run, cyc, amt;

    dsp_accum_saturate_round_shift i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .op(op),
        .writeback_pointer(ptr), .xbus_wr(xbus_wr), .ptr_wr(ptr_wr),
        .shift_result(shift_result), .shift_word(shift_word), .arith_trap(arith_trap));
    dsp_xbus_model i_far (.hclk(hclk), .hresetn(hresetn), .xbus_wr(xbus_wr), .ptr_wr(ptr_wr),
        .ptr_q(ptr), .wr_cnt_q(wcnt));

    // clock and hang guard
    always #5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            test_done();
        end
    end

    task test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string n, input logic [39:0] s, input logic [39:0] x);
        tests_run++;
        if (s !== x)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, x, s);
        end
    endtask

    // one single word transfer, read data kept in rdv
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task rchk(input logic [7:0] a, input logic [39:0] x, input string n);
        ahb(1'b0, a, 32'h00000000);
        chk(n, {8'h00, rdv}, x);
    endtask

    // one decoder request, outputs settled on return
    task step(input dsp_pkg::dsp_op_s q);
        @(posedge hclk);
        op <= q;
        @(posedge hclk);
        op <= '0;
        #1;
    endtask

    task acc_op(input logic b, input logic [39:0] x, input logic sub, input logic zero);
        dsp_pkg::dsp_op_s q;
        q = '0;
        q.add_en = 1'b1;
        q.add_target_b = b;
        q.add_sub = sub;
        q.add_zero = zero;
        q.addend = x;
        step(q);
    endtask

    // reference store word: rounding then write saturation
    function automatic logic [15:0] rnd_word(input logic [39:0] a, input logic conv,
        input logic rnd, input logic sat);
        int r;
        r = $signed(a[39:16]);
        if (rnd)
            r = r + ((a[15:0] == 16'h8000 && !conv) ? int'(a[16]) : int'(a[15]));
        if (sat && r > 32767)
            return 16'h7FFF;
        if (sat && r < -32768)
            return 16'h8000;
        return r[15:0];
    endfunction

    // reference shifter: positive right, negative left
    function automatic logic [39:0] shf(input logic [39:0] x, input int n, input logic l);
        logic signed [39:0] s;
        s = x;
        if (n < 0)
            return x << (-n);
        if (l)
            return x >> n;
        return s >>> n;
    endfunction

    initial
    begin
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        op = '0;
        rdv = $urandom(32'h9F16);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(dsp_pkg::OFS_CORE_CTRL, 40'h0, "ctrl_rst");
        rchk(dsp_pkg::OFS_TRAP_CTRL, 40'h0, "trap_rst");
        rchk(dsp_pkg::OFS_STATUS, 40'h0, "stat_rst");
        chk("hresp", hresp, 1'b0);
        rchk(8'h1C, 40'h0, "unmapped");
        $display("test reset done");
        ahb(1'b1, dsp_pkg::OFS_TRAP_CTRL, 32'h1);
        acc_op(1'b0, 40'h01_0000_0000, 1'b0, 1'b1);
        chk("trap_a", arith_trap, 1'b1);
        @(posedge hclk);
        #1;
        chk("trap_len", arith_trap, 1'b0);
        acc_op(1'b1, 40'h01_0000_0000, 1'b0, 1'b1);
        chk("trap_b_off", arith_trap, 1'b0);
        rchk(dsp_pkg::OFS_STATUS, 40'hC800, "guard_both");
        acc_op(1'b0, 40'h0, 1'b0, 1'b1);
        acc_op(1'b1, 40'h1234, 1'b0, 1'b1);
        rchk(dsp_pkg::OFS_STATUS, 40'h0, "guard_clr");
        $display("test guard done");
        ahb(1'b1, dsp_pkg::OFS_TRAP_CTRL, 32'h4);
        acc_op(1'b0, 40'h7F_FFFF_FFFF, 1'b0, 1'b1);
        acc_op(1'b0, 40'h1, 1'b0, 1'b0);
        chk("cat_trap", arith_trap, 1'b1);
        rchk(dsp_pkg::OFS_ACCA_HI, 40'h80, "cat_wrap");
        rchk(dsp_pkg::OFS_STATUS, 40'hAC00, "cat_stat");
        acc_op(1'b0, 40'h0, 1'b0, 1'b1);
        rchk(dsp_pkg::OFS_STATUS, 40'h2400, "sticky");
        ahb(1'b1, dsp_pkg::OFS_STATUS, 32'h2000);
        rchk(dsp_pkg::OFS_STATUS, 40'h0, "w1c");
        $display("test catastrophic done");
        ahb(1'b1, dsp_pkg::OFS_CORE_CTRL, 32'h90);
        acc_op(1'b0, 40'h7F_FFFF_FFFF, 1'b0, 1'b1);
        acc_op(1'b0, 40'h1, 1'b0, 1'b0);
        chk("sat_notrap", arith_trap, 1'b0);
        rchk(dsp_pkg::OFS_ACCA_HI, 40'h7F, "s40p_hi");
        rchk(dsp_pkg::OFS_ACCA_LO, 40'hFFFF_FFFF, "s40p_lo");
        ahb(1'b0, dsp_pkg::OFS_STATUS, 32'h0);
        chk("s40_flag", rdv & 32'h2400, 40'h2400);
        acc_op(1'b0, 40'h80_0000_0000, 1'b0, 1'b1);
        acc_op(1'b0, 40'h1, 1'b1, 1'b0);
        rchk(dsp_pkg::OFS_ACCA_HI, 40'h80, "s40n_hi");
        rchk(dsp_pkg::OFS_ACCA_LO, 40'h0, "s40n_lo");
        ahb(1'b1, dsp_pkg::OFS_CORE_CTRL, 32'h80);
        ahb(1'b1, dsp_pkg::OFS_STATUS, 32'h2000);
        acc_op(1'b0, 40'h7FFF_FFFF, 1'b0, 1'b1);
        acc_op(1'b0, 40'h1, 1'b0, 1'b0);
        rchk(dsp_pkg::OFS_ACCA_LO, 40'h7FFF_FFFF, "s32p_lo");
        ahb(1'b0, dsp_pkg::OFS_STATUS, 32'h0);
        chk("s32_flag", rdv & 32'hA400, 40'h2400);
        acc_op(1'b0, 40'hFF_8000_0000, 1'b0, 1'b1);
        acc_op(1'b0, 40'h1, 1'b1, 1'b0);
        rchk(dsp_pkg::OFS_ACCA_HI, 40'hFF, "s32n_hi");
        rchk(dsp_pkg::OFS_ACCA_LO, 40'h8000_0000, "s32n_lo");
        ahb(1'b1, dsp_pkg::OFS_STATUS, 32'h3000);
        ahb(1'b1, dsp_pkg::OFS_TRAP_CTRL, 32'h0);
        $display("test saturation done");
        for (int k = 0; k < 16; k++)
        begin
            v = {8'($urandom), 32'($urandom)};
            if (k % 2 == 1)
                v[39:31] = {9{v[31]}};
            if (k % 4 == 2)
                v[15:0] = 16'h8000;
            {cv, sd, rr} = 3'($urandom);
            ahb(1'b1, dsp_pkg::OFS_CORE_CTRL, {26'h0, sd, 3'h0, cv, 1'b0});
            acc_op(1'b1, v, 1'b0, 1'b1);
            o = '0;
            o.store_en = 1'b1;
            o.store_src_b = 1'b1;
            o.store_round = rr;
            o.store_addr = 16'($urandom) & 16'hFFFE;
            step(o);
            chk("st_en", xbus_wr.en, 1'b1);
            chk("st_addr", xbus_wr.addr, o.store_addr);
            chk("st_data", xbus_wr.data, rnd_word(v, cv, rr, sd));
            rchk(dsp_pkg::OFS_ACCB_HI, v[39:32], "st_src");
        end
        $display("test store done");
        ahb(1'b1, dsp_pkg::OFS_CORE_CTRL, 32'h2);
        for (int k = 0; k < 12; k++)
        begin
            c = dsp_pkg::op_class_e'(k % 6);
            ind = (k >= 6);
            v = {8'($urandom), 32'($urandom)};
            acc_op(1'b1, v, 1'b0, 1'b1);
            o = '0;
            o.add_en = 1'b1;
            o.op_class = c;
            o.wb_en = 1'b1;
            o.wb_indirect = ind;
            p = ptr;
            step(o);
            ok = (c == dsp_pkg::class_mac || c == dsp_pkg::class_other);
            w = rnd_word(v, 1'b1, 1'b1, 1'b0);
            chk("wb_bus", xbus_wr.en, ok & ind);
            chk("wb_ptr", ptr_wr.en, ok);
            if (ok && ind)
            begin
                chk("wb_addr", xbus_wr.addr, p);
                chk("wb_data", xbus_wr.data, w);
                chk("wb_step", ptr_wr.value, 16'(p + dsp_pkg::WB_PTR_STEP));
            end
            if (ok && !ind)
                chk("wb_reg", ptr_wr.value, w);
        end
        chk("wr_cnt", wcnt, 40'h12);
        $display("test write back done wr %0d", wcnt);
        for (int k = 0; k < 20; k++)
        begin
            amt = (k == 0) ? 0 : int'($urandom % 33) - 16;
            lg = 1'($urandom);
            v = {8'($urandom), 32'($urandom)};
            o = '0;
            o.shift_en = 1'b1;
            o.shift_logical = lg;
            o.shift_amt = amt[5:0];
            o.xbus_data = v[15:0];
            if (k % 2 == 1 && amt != 0)
            begin
                o.shift_src = dsp_pkg::src_xbus;
                e = (amt < 0) ? {24'h0, v[15:0]} : {lg ? 8'h00 : {8{v[15]}}, v[15:0], 16'h0};
                e = shf(e, amt, lg);
                w = (amt < 0) ? e[15:0] : e[31:16];
            end
            else
            begin
                acc_op(1'b0, v, 1'b0, 1'b1);
                o.shift_src = dsp_pkg::src_acc_a;
                e = shf(v, amt, lg);
                w = e[31:16];
            end
            step(o);
            chk("shift40", shift_result, e);
            chk("shift16", shift_word, w);
        end
        $display("test shift done");
        test_done();
    end
endmodule // dsp_accum_saturate_round_shift_tb_top

// ---- dsp_pkg.sv ----
package dsp_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CORE_CTRL = 8'h00;
    localparam logic [7:0] OFS_TRAP_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ACCA_LO = 8'h0C;
    localparam logic [7:0] OFS_ACCA_HI = 8'h10;
    localparam logic [7:0] OFS_ACCB_LO = 8'h14;
    localparam logic [7:0] OFS_ACCB_HI = 8'h18;
    // core_control_word fields
    localparam int POS_LIMIT_EN_A = 7;
    localparam int POS_LIMIT_EN_B = 6;
    localparam int POS_STORE_LIMIT = 5;
    localparam int POS_LIMIT_WIDTH = 4;
    localparam int POS_ROUND_STYLE = 1;
    localparam logic [7:0] CORE_CTRL_RST = 8'h00;
    // interrupt_control_one fields
    localparam int POS_GUARD_TRAP_A = 0;
    localparam int POS_GUARD_TRAP_B = 1;
    localparam int POS_CAT_TRAP = 2;
    localparam logic [2:0] TRAP_CTRL_RST = 3'h0;
    // cpu_status_word fields
    localparam int POS_GUARD_A = 15;
    localparam int POS_GUARD_B = 14;
    localparam int POS_LIMIT_A = 13;
    localparam int POS_LIMIT_B = 12;
    localparam int POS_EITHER_GUARD = 11;
    localparam int POS_EITHER_LIMIT = 10;
    // saturation targets and store limits
    localparam logic [39:0] SAT40_POS = 40'h7F_FFFF_FFFF;
    localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
    localparam logic [39:0] SAT32_POS = 40'h00_7FFF_FFFF;
    localparam logic [39:0] SAT32_NEG = 40'hFF_8000_0000;
    localparam logic [15:0] STORE_MAX = 16'h7FFF;
    localparam logic [15:0] STORE_MIN = 16'h8000;
    localparam logic signed [24:0] STORE_UPPER = 25'sh0007FFF;
    localparam logic signed [24:0] STORE_LOWER = 25'sh1FF8000;
    localparam logic [15:0] WB_PTR_STEP = 16'h0002;

    typedef enum logic [2:0] {class_mac, class_other, plain_multiply, negative_multiply,
        squared_difference, squared_difference_accumulate} op_class_e;
    typedef enum logic [1:0] {src_acc_a, src_acc_b, src_xbus} shift_src_e;

    typedef struct packed {
        logic add_en;
        logic add_target_b;
        logic add_sub;
        logic add_zero;
        logic [39:0] addend;
        op_class_e op_class;
        logic wb_en;
        logic wb_indirect;
        logic store_en;
        logic store_src_b;
        logic store_round;
        logic [15:0] store_addr;
        logic shift_en;
        shift_src_e shift_src;
        logic shift_logical;
        logic signed [5:0] shift_amt;
        logic [15:0] xbus_data;
    } dsp_op_s;

    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [15:0] data;
    } xbus_wr_s;

    typedef struct packed {
        logic en;
        logic [15:0] value;
    } ptr_wr_s;
endpackage

// ---- dsp_xbus_model.sv ----
`timescale 1ns/1ns
// far side of the block: pointer register and data memory write port
module dsp_xbus_model #(
    parameter logic [15:0] PTR_INIT = 16'h0100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire dsp_pkg::xbus_wr_s xbus_wr,
    input wire dsp_pkg::ptr_wr_s ptr_wr,
    output logic [15:0] ptr_q,
    output logic [15:0] wr_cnt_q
);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ptr_q <= PTR_INIT;
        else if (ptr_wr.en)
            ptr_q <= ptr_wr.value;
    end
    // count of data memory writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wr_cnt_q <= 16'h0000;
        else if (xbus_wr.en)
            wr_cnt_q <= wr_cnt_q + 16'h0001;
    end
endmodule // dsp_xbus_model
